// file: src/position_information_encap_defs.vh
// Constants for the position and training data packet encapsulator
`ifndef POSITION_INFORMATION_ENCAP_DEFS_VH
`define POSITION_INFORMATION_ENCAP_DEFS_VH
// Channel-specific word fields
`define CSW_TS_BIT 31
`define CSW_CONTENT_HI 30
`define CSW_CONTENT_LO 29
`define CSW_SUBFMT_HI 30
`define CSW_SUBFMT_LO 27
// Content codes for format 1
`define CONTENT_POS_ONLY 2'h0
`define CONTENT_WITH_STATIC 2'h1
// Highest legal sub-format code for format 2
`define SUBFMT_MAX 4'h8
// Packet flag positions
`define FLAG_ABS_TIME_BIT 6
`define FLAG_TIME_FMT_HI 3
`define FLAG_TIME_FMT_LO 2
// Time stamp is 8 bytes, four 16-bit words
`define TS_LAST_IDX 2'h3
// Relative time counter width and reset value
`define RTC_WIDTH 48
`define RTC_RESET 48'h000000000000
// Odd-length filler byte and reserved fill
`define FILLER_BYTE 8'h00
`define RSVD_HALF 16'h0000
// Packet format select
`define FMT_ONE 1'b0
`define FMT_TWO 1'b1
`endif

// file: src/rtc_counter.v
// Free-running relative time counter
`timescale 1ns/10ps
`default_nettype none
`include "position_information_encap_defs.vh"
module rtc_counter #(
  parameter WIDTH = `RTC_WIDTH
) (
  // Clock and control
  input wire mclk,
  input wire sys_rst,
  input wire clk_en,
  // Counter value
  output wire [WIDTH-1:0] rtc_value
);
  reg [WIDTH-1:0] count_reg;

  // Advances once per enabled cycle; wraps silently
  always @(posedge mclk) begin
    if (sys_rst) begin
      count_reg <= `RTC_RESET;
    end else if (clk_en) begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign rtc_value = count_reg;
endmodule
`default_nettype wire

// file: src/byte_packer.v
// Packs bytes two to a 16-bit word, filler on odd count
`timescale 1ns/10ps
`default_nettype none
`include "position_information_encap_defs.vh"
module byte_packer (
  // Clock and control
  input wire mclk,
  input wire sys_rst,
  input wire clk_en,
  // Byte side
  input wire byte_valid,
  input wire [7:0] byte_data,
  input wire byte_last,
  output wire byte_ready,
  // Word side
  output wire word_valid,
  output wire [15:0] word_data,
  input wire word_ready
);
  reg [7:0] lo_reg;
  reg have_lo_reg;
  reg [15:0] word_reg;
  reg wvalid_reg;
  wire take;

  // Stall bytes while a finished word waits
  assign byte_ready = !wvalid_reg || word_ready;
  assign take = byte_valid && byte_ready;

  // First byte in low half, second or filler in high half
  always @(posedge mclk) begin
    if (sys_rst) begin
      lo_reg <= 8'h00;
      have_lo_reg <= 1'b0;
      word_reg <= 16'h0000;
      wvalid_reg <= 1'b0;
    end else if (clk_en) begin
      if (word_ready) begin
        wvalid_reg <= 1'b0;
      end
      if (take) begin
        if (have_lo_reg) begin
          word_reg <= {byte_data, lo_reg};
          wvalid_reg <= 1'b1;
          have_lo_reg <= 1'b0;
        end else if (byte_last) begin
          word_reg <= {`FILLER_BYTE, byte_data};
          wvalid_reg <= 1'b1;
        end else begin
          lo_reg <= byte_data;
          have_lo_reg <= 1'b1;
        end
      end
    end
  end

  assign word_valid = wvalid_reg;
  assign word_data = word_reg;
endmodule
`default_nettype wire

// file: src/position_information_packet_encapsulator.v
// Packet body builder for position and combat-training data
//
// Operation
// - bit 31 flags time stamps present
// - format 1 content code 00 or 01
// - format 1 bits 28-0 carry nothing
// - format 1 one stamp, low word first
// - static data untagged, precedes position data
// - relative stamp is 48-bit counter, high zero
// - flag bit 6 selects absolute time
// - stamp taken at block's first bit
// - 4-byte header, length in bits 15-0
// - payload handled as 8-bit bytes
// - two bytes per word, filler high
// - format 2 messages never split
// - format 2 sub-format codes 0 to 8
// - format 2 bits 26-0 reserved
// - format 2 stamp before every message
`timescale 1ns/10ps
`default_nettype none
`include "position_information_encap_defs.vh"
module position_information_packet_encapsulator (
  // Clock, reset, enable
  input wire mclk,
  input wire sys_rst,
  input wire clk_en,
  // Packet setup
  input wire pkt_start,
  input wire pkt_format,
  input wire pkt_ts_en,
  input wire [1:0] pkt_content,
  input wire [3:0] pkt_subfmt,
  input wire [7:0] pkt_flags,
  input wire pkt_close,
  output wire pkt_ready,
  output wire pkt_err,
  output wire pkt_end,
  output wire [1:0] time_fmt,
  output wire busy,
  // Message announce
  input wire msg_valid,
  input wire [15:0] msg_len,
  output wire msg_ready,
  // Absolute time source
  input wire [63:0] abs_time,
  // Payload bytes
  input wire byte_valid,
  input wire [7:0] byte_data,
  output wire byte_ready,
  // Word stream toward the recorder
  output wire word_valid,
  output wire [15:0] word_data,
  input wire word_ready
);
  localparam ST_IDLE = 4'h0;
  localparam ST_CSW_L = 4'h1;
  localparam ST_CSW_H = 4'h2;
  localparam ST_WAIT = 4'h3;
  localparam ST_TS = 4'h4;
  localparam ST_HDR_L = 4'h5;
  localparam ST_HDR_H = 4'h6;
  localparam ST_PAY = 4'h7;
  localparam ST_DONE = 4'h8;

  reg [3:0] state_reg, state_next;
  reg fmt_reg, fmt_next;
  reg ts_en_reg, ts_en_next;
  reg [1:0] content_reg, content_next;
  reg [3:0] subfmt_reg, subfmt_next;
  reg [7:0] flags_reg, flags_next;
  reg [15:0] len_reg, len_next;
  reg [63:0] ts_reg, ts_next;
  reg [1:0] ts_idx_reg, ts_idx_next;
  reg [15:0] byte_left_reg, byte_left_next;
  reg [15:0] word_left_reg, word_left_next;
  reg [15:0] out_data_reg, out_data_next;
  reg out_valid_reg, out_valid_next;
  reg err_reg, err_next;
  reg end_reg, end_next;

  wire [`RTC_WIDTH-1:0] rtc_value;
  wire out_free;
  wire [31:0] csw;
  wire [16:0] len_plus;
  wire bad_code;
  wire pk_byte_valid;
  wire pk_byte_ready;
  wire pk_byte_last;
  wire pk_word_valid;
  wire [15:0] pk_word_data;
  wire pk_word_ready;
  wire byte_fire;
  reg [15:0] ts_word;

  rtc_counter #(
    .WIDTH(`RTC_WIDTH)
  ) u_rtc (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .rtc_value(rtc_value)
  );

  byte_packer u_packer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .byte_valid(pk_byte_valid),
    .byte_data(byte_data),
    .byte_last(pk_byte_last),
    .byte_ready(pk_byte_ready),
    .word_valid(pk_word_valid),
    .word_data(pk_word_data),
    .word_ready(pk_word_ready)
  );

  // Output stage can take a word when empty or being drained
  assign out_free = !out_valid_reg || word_ready;

  // Reserved codes are refused at setup, never emitted
  assign bad_code = (pkt_format == `FMT_ONE) ? pkt_content[1] : (pkt_subfmt > `SUBFMT_MAX);

  // Channel-specific word, reserved bits zero
  assign csw = (fmt_reg == `FMT_ONE) ?
    {ts_en_reg, content_reg, 29'h0} :
    {ts_en_reg, subfmt_reg, 27'h0};

  // Word count rounds up for an odd byte
  assign len_plus = {1'b0, len_reg} + 17'h1;

  // Byte path only opens during payload and while bytes remain
  assign pk_byte_valid = (state_reg == ST_PAY) && (byte_left_reg != 16'h0000) && byte_valid;
  assign byte_ready = clk_en && (state_reg == ST_PAY) && (byte_left_reg != 16'h0000) && pk_byte_ready;
  assign byte_fire = byte_valid && byte_ready;
  assign pk_byte_last = (byte_left_reg == 16'h0001);
  assign pk_word_ready = (state_reg == ST_PAY) && out_free;

  // Stamp words in order 15-0, 31-16, 47-32, 63-48
  always @* begin
    case (ts_idx_reg)
      2'h0: ts_word = ts_reg[15:0];
      2'h1: ts_word = ts_reg[31:16];
      2'h2: ts_word = ts_reg[47:32];
      default: ts_word = ts_reg[63:48];
    endcase
  end

  // Sequencer; every load waits for the output stage to be free
  always @* begin
    state_next = state_reg;
    fmt_next = fmt_reg;
    ts_en_next = ts_en_reg;
    content_next = content_reg;
    subfmt_next = subfmt_reg;
    flags_next = flags_reg;
    len_next = len_reg;
    ts_next = ts_reg;
    ts_idx_next = ts_idx_reg;
    byte_left_next = byte_left_reg;
    word_left_next = word_left_reg;
    out_data_next = out_data_reg;
    out_valid_next = out_valid_reg && !word_ready;
    err_next = 1'b0;
    end_next = 1'b0;
    if (byte_fire) begin
      byte_left_next = byte_left_reg - 16'h0001;
    end
    case (state_reg)
      ST_IDLE: begin
        if (pkt_start) begin
          if (bad_code) begin
            err_next = 1'b1;
          end else begin
            fmt_next = pkt_format;
            ts_en_next = pkt_ts_en;
            content_next = pkt_content;
            subfmt_next = pkt_subfmt;
            flags_next = pkt_flags;
            state_next = ST_CSW_L;
          end
        end
      end
      ST_CSW_L: begin
        if (out_free) begin
          out_valid_next = 1'b1;
          out_data_next = csw[15:0];
          state_next = ST_CSW_H;
        end
      end
      ST_CSW_H: begin
        if (out_free) begin
          out_valid_next = 1'b1;
          out_data_next = csw[31:16];
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // A new block is announced at its first data bit
        if (msg_valid) begin
          len_next = msg_len;
          byte_left_next = msg_len;
          ts_idx_next = 2'h0;
          if (flags_reg[`FLAG_ABS_TIME_BIT]) begin
            ts_next = abs_time;
          end else begin
            ts_next = {`RSVD_HALF, rtc_value};
          end
          state_next = ts_en_reg ? ST_TS : ST_HDR_L;
        end else if ((fmt_reg == `FMT_TWO) && pkt_close) begin
          state_next = ST_DONE;
        end
      end
      ST_TS: begin
        if (out_free) begin
          out_valid_next = 1'b1;
          out_data_next = ts_word;
          ts_idx_next = ts_idx_reg + 2'h1;
          if (ts_idx_reg == `TS_LAST_IDX) begin
            state_next = ST_HDR_L;
          end
        end
      end
      ST_HDR_L: begin
        if (out_free) begin
          out_valid_next = 1'b1;
          out_data_next = len_reg;
          word_left_next = len_plus[16:1];
          state_next = ST_HDR_H;
        end
      end
      ST_HDR_H: begin
        if (out_free) begin
          out_valid_next = 1'b1;
          out_data_next = `RSVD_HALF;
          if (word_left_reg == 16'h0000) begin
            state_next = (fmt_reg == `FMT_TWO) ? ST_WAIT : ST_DONE;
          end else begin
            state_next = ST_PAY;
          end
        end
      end
      ST_PAY: begin
        // Whole message goes out before another may start
        if (out_free && pk_word_valid) begin
          out_valid_next = 1'b1;
          out_data_next = pk_word_data;
          word_left_next = word_left_reg - 16'h0001;
          if (word_left_reg == 16'h0001) begin
            state_next = (fmt_reg == `FMT_TWO) ? ST_WAIT : ST_DONE;
          end
        end
      end
      ST_DONE: begin
        end_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State registers, frozen while the clock enable is low
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      fmt_reg <= `FMT_ONE;
      ts_en_reg <= 1'b0;
      content_reg <= `CONTENT_POS_ONLY;
      subfmt_reg <= 4'h0;
      flags_reg <= 8'h00;
      len_reg <= 16'h0000;
      ts_reg <= 64'h0000000000000000;
      ts_idx_reg <= 2'h0;
      byte_left_reg <= 16'h0000;
      word_left_reg <= 16'h0000;
      out_data_reg <= 16'h0000;
      out_valid_reg <= 1'b0;
      err_reg <= 1'b0;
      end_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      fmt_reg <= fmt_next;
      ts_en_reg <= ts_en_next;
      content_reg <= content_next;
      subfmt_reg <= subfmt_next;
      flags_reg <= flags_next;
      len_reg <= len_next;
      ts_reg <= ts_next;
      ts_idx_reg <= ts_idx_next;
      byte_left_reg <= byte_left_next;
      word_left_reg <= word_left_next;
      out_data_reg <= out_data_next;
      out_valid_reg <= out_valid_next;
      err_reg <= err_next;
      end_reg <= end_next;
    end
  end

  // Handshakes combinational, data from flops
  assign pkt_ready = clk_en && (state_reg == ST_IDLE);
  assign msg_ready = clk_en && (state_reg == ST_WAIT);
  assign busy = (state_reg != ST_IDLE);
  assign pkt_err = err_reg;
  assign pkt_end = end_reg;
  assign time_fmt = flags_reg[`FLAG_TIME_FMT_HI:`FLAG_TIME_FMT_LO];
  assign word_valid = clk_en && out_valid_reg; // Frozen stage must not hand a word over twice
  assign word_data = out_data_reg;
endmodule
`default_nettype wire

// file: testbench/position_information_encap_monitor.sv
// Port-level checker for the packet encapsulator
`timescale 1ns/10ps
`default_nettype none
module position_information_encap_monitor (
  // Clock and control
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Packet setup
  input wire logic pkt_start,
  input wire logic pkt_format,
  input wire logic [1:0] pkt_content,
  input wire logic [3:0] pkt_subfmt,
  input wire logic [7:0] pkt_flags,
  input wire logic pkt_ready,
  input wire logic pkt_err,
  input wire logic [1:0] time_fmt,
  input wire logic busy,
  // Streams
  input wire logic msg_valid,
  input wire logic msg_ready,
  input wire logic byte_ready,
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  input wire logic word_ready
);
  reg fmt_reg;
  reg [1:0] msg_cnt_reg;
  wire take = pkt_ready & pkt_start;
  wire bad = pkt_format ? (pkt_subfmt > 4'h8) : pkt_content[1];
  wire [1:0] flag_fmt = pkt_flags[3:2];
  // Messages taken in the current packet, saturating
  always @(posedge mclk) begin
    if (sys_rst) begin
      fmt_reg <= 1'b0;
      msg_cnt_reg <= 2'h0;
    end else if (take) begin
      fmt_reg <= pkt_format;
      msg_cnt_reg <= 2'h0;
    end else if (msg_valid & msg_ready & (msg_cnt_reg != 2'h3)) begin
      msg_cnt_reg <= msg_cnt_reg + 2'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_bad_content: assert property (take & ~pkt_format & pkt_content[1] |=> pkt_err & ~busy)
    else $error("reserved content accepted");
  chk_bad_subfmt: assert property (take & pkt_format & (pkt_subfmt > 4'h8) |=> pkt_err & ~busy)
    else $error("reserved sub-format accepted");
  chk_good_start: assert property (take & ~bad |=> busy & ~pkt_err)
    else $error("legal start not opened");
  chk_time_format: assert property (take & ~bad |=> time_fmt == $past(flag_fmt))
    else $error("time format not latched");
  chk_word_hold: assert property (word_valid & ~word_ready & clk_en ##1 clk_en |-> word_valid & $stable(word_data))
    else $error("word dropped under stall");
  chk_one_block: assert property (busy & ~fmt_reg |-> msg_cnt_reg <= 2'h1)
    else $error("second block in format 1");
  chk_err_cause: assert property (pkt_err |-> ~busy & $past(take))
    else $error("error without refused start");
  chk_frozen: assert property (~clk_en |-> ~pkt_ready & ~msg_ready & ~byte_ready & ~word_valid)
    else $error("handshake while frozen");
endmodule
bind position_information_packet_encapsulator position_information_encap_monitor mon_u (.mclk, .sys_rst, .clk_en, .pkt_start, .pkt_format,
  .pkt_content, .pkt_subfmt, .pkt_flags, .pkt_ready, .pkt_err, .time_fmt, .busy, .msg_valid, .msg_ready,
  .byte_ready, .word_valid, .word_data, .word_ready);
`default_nettype wire

// file: testbench/recorder_sink.sv
// Recorder-side model taking the word stream
`timescale 1ns/10ps
`default_nettype none
module recorder_sink (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Stall request from the bench
  input wire logic stall,
  // Word stream
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  output logic word_ready
);
  logic [15:0] got[$];
  // Ready alternates while stalling so every hold path is hit
  // Moves just after the rising edge, so the bench sees it settled at the falling edge
  always @(posedge mclk) word_ready <= sys_rst | ~stall | ~word_ready;
  // Handshaken words kept in arrival order
  always @(posedge mclk) if (!sys_rst && word_valid && word_ready) got.push_back(word_data);
endmodule
`default_nettype wire

// file: testbench/test_position_information_packet_encapsulator.sv
// Self-checking bench for the packet encapsulator
`timescale 1ns/10ps
`default_nettype none
module test_position_information_packet_encapsulator;
  logic mclk, sys_rst, clk_en, pkt_start, pkt_format, pkt_ts_en, pkt_close, stall, msg_valid, byte_valid;
  logic [1:0] pkt_content;
  logic [3:0] pkt_subfmt;
  logic [7:0] pkt_flags, byte_data;
  logic [15:0] msg_len;
  logic [63:0] abs_time;
  wire pkt_ready, pkt_err, pkt_end, busy, msg_ready, byte_ready, word_valid, word_ready;
  wire [1:0] time_fmt;
  wire [15:0] word_data;
  logic [15:0] exp_q[$];
  bit msk_q[$];
  int miscompares, cmp_count;
  logic [47:0] rtc_model;
  position_information_packet_encapsulator dut_u (.mclk, .sys_rst, .clk_en, .pkt_start, .pkt_format, .pkt_ts_en, .pkt_content,
    .pkt_subfmt, .pkt_flags, .pkt_close, .pkt_ready, .pkt_err, .pkt_end, .time_fmt, .busy, .msg_valid,
    .msg_len, .msg_ready, .abs_time, .byte_valid, .byte_data, .byte_ready, .word_valid, .word_data, .word_ready);
  recorder_sink sink_u (.mclk, .sys_rst, .stall, .word_valid, .word_data, .word_ready);
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Relative time model: zero in reset, one count per enabled cycle
  always @(posedge mclk) begin
    if (sys_rst) begin
      rtc_model <= 48'h0;
    end else if (clk_en) begin
      rtc_model <= rtc_model + 48'h1;
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task put(input logic [15:0] w, input bit m);
    exp_q.push_back(w);
    msk_q.push_back(m);
  endtask
  // Open a packet; the expected channel word goes first
  task start_pkt(input bit f, input bit ts, input logic [3:0] code, input logic [7:0] flags);
    pkt_format = f;
    pkt_ts_en = ts;
    pkt_content = code[1:0];
    pkt_subfmt = code;
    pkt_flags = flags;
    pkt_start = 1'b1;
    repeat (500) if (!pkt_ready) @(negedge mclk);
    @(posedge mclk);
    @(negedge mclk);
    pkt_start = 1'b0;
    put(16'h0000, 1);
    put(f ? {ts, code, 11'h0} : {ts, code[1:0], 13'h0}, 1);
  endtask
  // Stamp expected from the counter model at the edge the message is taken
  task send_msg(input bit ts, input bit ab, input logic [15:0] len, input logic [7:0] base);
    int j;
    logic [63:0] stamp;
    msg_valid = 1'b1;
    msg_len = len;
    repeat (500) if (!msg_ready) @(negedge mclk);
    @(posedge mclk);
    stamp = ab ? abs_time : {16'h0000, rtc_model};
    @(negedge mclk);
    msg_valid = 1'b0;
    for (j = 0; j < 4; j++) if (ts) put(stamp[16*j +: 16], 1'b1);
    put(len, 1);
    put(16'h0000, 1);
    for (j = 0; j < len; j += 2) put({(j + 1 < len) ? base + 8'(j + 1) : 8'h00, base + 8'(j)}, 1);
    for (j = 0; j < len; j++) begin
      byte_valid = 1'b1;
      byte_data = base + 8'(j);
      repeat (500) if (!byte_ready) @(negedge mclk);
      @(posedge mclk);
      @(negedge mclk);
    end
    byte_valid = 1'b0;
    @(negedge mclk);
  endtask
  task cmp_pkt;
    check(16'(sink_u.got.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) if (msk_q[i] && i < sink_u.got.size()) check(sink_u.got[i], exp_q[i]);
    exp_q.delete();
    msk_q.delete();
    sink_u.got.delete();
  endtask
  task finish_pkt(input bit f);
    pkt_close = f;
    repeat (2000) if (!pkt_end) @(negedge mclk);
    check({15'h0000, pkt_end}, 16'h0001);
    pkt_close = 1'b0;
    repeat (8) @(negedge mclk);
    cmp_pkt();
  endtask
  // Format 1 with static data and an odd byte count
  task test_static_odd;
    start_pkt(1'b0, 1'b0, 4'h1, 8'h00);
    send_msg(1'b0, 1'b0, 16'h0003, 8'h41);
    finish_pkt(1'b0);
    $display("test_static_odd done");
  endtask
  // Absolute stamp behind a frozen enable and a stalling recorder
  task test_abs_stamp;
    clk_en = 1'b0;
    repeat (3) @(negedge mclk);
    check({15'h0000, pkt_ready}, 16'h0000);
    clk_en = 1'b1;
    stall = 1'b1;
    start_pkt(1'b0, 1'b1, 4'h0, 8'h48);
    send_msg(1'b1, 1'b1, 16'h0002, 8'h61);
    check({14'h0000, time_fmt}, 16'h0002);
    finish_pkt(1'b0);
    stall = 1'b0;
    $display("test_abs_stamp done");
  endtask
  // Format 2, relative stamps, several messages in one packet
  task test_multi_msg;
    start_pkt(1'b1, 1'b1, 4'h8, 8'h00);
    send_msg(1'b1, 1'b0, 16'h0001, 8'h11);
    send_msg(1'b1, 1'b0, 16'h0000, 8'h21);
    send_msg(1'b1, 1'b0, 16'h0004, 8'h31);
    finish_pkt(1'b1);
    $display("test_multi_msg done");
  endtask
  // Every sub-format code, then the reserved content codes
  task test_code_table;
    for (int c = 0; c < 18; c++) begin
      start_pkt(c < 16, 1'b0, 4'(c < 16 ? c : c - 14), 8'h00);
      if (c < 9) begin
        send_msg(1'b0, 1'b0, 16'h0002, 8'hA0);
        finish_pkt(1'b1);
      end else begin
        check({15'h0000, pkt_err}, 16'h0001);
        check({15'h0000, busy}, 16'h0000);
        exp_q.delete();
        msk_q.delete();
        @(negedge mclk);
        cmp_pkt();
      end
    end
    $display("test_code_table done");
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    {pkt_start, pkt_format, pkt_ts_en, pkt_close, stall, msg_valid, byte_valid} = 7'h00;
    {pkt_content, pkt_subfmt, pkt_flags, byte_data, msg_len} = 38'h0;
    abs_time = 64'h0123_4567_89AB_CDEF;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    test_static_odd();
    test_abs_stamp();
    test_multi_msg();
    test_code_table();
    results();
  end
  // Watchdog far beyond the few hundred cycles the run needs
  initial begin
    #(40 * 20000);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
